// [hdl/adc_conversion_control.v]
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "adc_defs.vh"

module adc_conversion_control (
  input  wire       clock,              // Peripheral clock, 25 MHz.
  input  wire       rstn,               // Asynchronous reset, active low.
  input  wire [7:0] address,            // Register address.
  input  wire [7:0] writeData,          // Register write data.
  input  wire       writeStrobe,        // One-cycle write request.
  input  wire       readStrobe,         // One-cycle read request.
  output reg  [7:0] readData,           // Read data, valid the cycle after the strobe.
  input  wire       compareAbove,       // Analog comparator: input at or above trial level.
  input  wire       globalIntEnable,    // Global interrupt enable from the CPU.
  input  wire       otherIrqPending,    // Any other interrupt request of the system.
  output reg  [2:0] channelSelect,      // Analog multiplexer select.
  output reg  [7:0] analogInputEnable,  // Port 1 pins handed to the converter.
  output reg        converterPowerOn,   // Analog power, low in standby.
  output reg        sampleHold,         // High during the sample period.
  output reg  [9:0] trialCode,          // Trial level driven to the analog ladder.
  output reg        cpuHalt,            // Stops the CPU during a precision conversion.
  output reg        cpuWake,            // Wake request to the halted CPU.
  output reg        otherIrqRelease,    // Lets other interrupts through to the CPU.
  output reg        converterIrq,       // Converter interrupt request to the controller.
  output reg        irq                 // Level interrupt from the masked status bits.
);

  // --------------------------------------------------------------------------
  // State encoding
  // --------------------------------------------------------------------------
  localparam [2:0] STATE_IDLE    = 3'b001;  // Waiting for a start.
  localparam [2:0] STATE_SAMPLE  = 3'b010;  // Sample-and-hold period.
  localparam [2:0] STATE_CONVERT = 3'b100;  // Bit decision periods.

  // --------------------------------------------------------------------------
  // Software visible state
  // --------------------------------------------------------------------------
  reg        pseudoIdleSelect;     // Precision mode request for the next start.
  reg        powerEnable;          // Converter power enable.
  reg        endOfConversionFlag;  // Result ready flag.
  reg        startStatus;          // Start bit, reads high while busy.
  reg  [2:0] channelField;         // Channel select field.
  reg  [7:0] channelEnable;        // Channel enable register.
  reg  [4:0] prescaleValue;        // Clock prescale value.
  reg  [9:0] result;               // Last completed conversion.
  reg        converterIntEnable;   // Converter interrupt enable.
  reg  [1:0] intStatus;            // Sticky event bits.
  reg  [1:0] intMask;              // Interrupt mask, same layout.

  // --------------------------------------------------------------------------
  // Conversion engine state
  // --------------------------------------------------------------------------
  reg  [2:0] state;                // One-hot engine state.
  reg  [3:0] bitIndex;             // Bit being decided, 9 down to 0.
  reg        precisionRun;         // Mode latched at the start.
  wire       periodTick;           // End of one converter clock period.
  wire       writeControl;         // Write to the control register.
  wire       startRequest;         // Software asks for a conversion.
  wire       startAccepted;        // The request passes all checks.
  wire       startRefused;         // The request is dropped.
  wire       finishing;            // Last bit period ends this cycle.
  wire       abortRun;             // Standby entered while busy.
  wire       busy;                 // Engine is not idle.
  wire [9:0] decidedCode;          // Trial code after this period's decision.
  wire [9:0] finalCode;            // Code stored at completion.
  wire [1:0] intEvents;            // Events this cycle.
  wire [1:0] next_intStatus;       // Status after set and clear.
  wire       next_eoc;             // End flag after set and clear.
  wire       next_busy;            // Busy state for the next cycle.

  assign writeControl  = writeStrobe && (address == `ADDR_CONTROL);
  assign startRequest  = writeControl && writeData[`CTL_START_BIT];
  assign busy          = (state != STATE_IDLE);

  // standby refuses conversion
  // Power is taken from the same write so that one write can enable and start.
  assign startAccepted = startRequest && !busy &&
                         writeData[`CTL_POWER_ENABLE_BIT] &&
                         channelEnable[writeData[`CTL_CHANNEL_MSB:`CTL_CHANNEL_LSB]];
  assign startRefused  = startRequest && !busy && !startAccepted;

  assign finishing     = (state == STATE_CONVERT) && periodTick && (bitIndex == 4'd0);
  assign abortRun      = busy && (writeControl ? !writeData[`CTL_POWER_ENABLE_BIT] :
                                                 !powerEnable);

  // --------------------------------------------------------------------------
  // Converter clock
  // --------------------------------------------------------------------------
  // The divider restarts with each accepted start, so the sample period and
  // all ten bit periods are full converter clock periods.
  converter_clock_divider u_divider (
    .clock    (clock),
    .rstn     (rstn),
    .restart  (startAccepted),
    .prescale (prescaleValue),
    .tick     (periodTick)
  );

  // --------------------------------------------------------------------------
  // Successive decision
  // --------------------------------------------------------------------------
  // comparator keeps or drops bit
  // A trial bit is kept while the input stands at or above the trial level,
  // so an input above the reference ends at all ones and one below ground at
  // all zeros, with a straight line between.
  assign decidedCode = compareAbove ? trialCode :
                       (trialCode & ~(10'h001 << bitIndex));

  assign finalCode = precisionRun ? decidedCode : {decidedCode[9:2], 2'b00};

  // one sample then ten bits
  // The engine spends one period in sample and ten in convert.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state        <= STATE_IDLE;
      bitIndex     <= 4'd0;
      trialCode    <= 10'h000;
      sampleHold   <= 1'b0;
      precisionRun <= 1'b0;
    end else begin
      case (state)
        STATE_IDLE: begin
          // Mode is latched here so a later write cannot change a running job.
          if (startAccepted) begin
            state        <= STATE_SAMPLE;
            sampleHold   <= 1'b1;
            precisionRun <= writeData[`CTL_PSEUDO_IDLE_BIT];
          end
        end
        STATE_SAMPLE: begin
          if (abortRun) begin
            state      <= STATE_IDLE;
            sampleHold <= 1'b0;
          end else if (periodTick) begin
            state      <= STATE_CONVERT;
            sampleHold <= 1'b0;
            bitIndex   <= 4'd9;
            trialCode  <= 10'h200;
          end
        end
        STATE_CONVERT: begin
          if (abortRun) begin
            state     <= STATE_IDLE;
            trialCode <= 10'h000;
          end else if (periodTick) begin
            if (bitIndex == 4'd0) begin
              state     <= STATE_IDLE;
              trialCode <= 10'h000;
            end else begin
              // Keep the decision and raise the next lower trial bit.
              trialCode <= decidedCode | (10'h001 << (bitIndex - 4'd1));
              bitIndex  <= bitIndex - 4'd1;
            end
          end
        end
        default: begin
          state      <= STATE_IDLE;
          sampleHold <= 1'b0;
          trialCode  <= 10'h000;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Result register
  // --------------------------------------------------------------------------
  // result updates only on completion
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result <= `RESET_RESULT;
    end else if (finishing && powerEnable) begin
      result <= finalCode;
    end
  end

  // --------------------------------------------------------------------------
  // Flags and interrupt events
  // --------------------------------------------------------------------------
  // set wins over software clear
  // Writing zero clears the flag; writing one leaves it alone.
  assign next_eoc = (finishing && powerEnable) ||
                    (endOfConversionFlag && !(writeControl && !writeData[`CTL_EOC_BIT]));

  assign intEvents = {startRefused, finishing && powerEnable};

  // Sticky bits: writing one clears, a fresh event in the same cycle wins.
  assign next_intStatus = intEvents |
                          (intStatus & ~((writeStrobe && address == `ADDR_INT_STATUS) ?
                                         writeData[1:0] : 2'b00));

  assign next_busy = (busy && !finishing && !abortRun) || startAccepted;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      endOfConversionFlag <= 1'b0;
      startStatus         <= 1'b0;
      intStatus           <= `RESET_INT;
    end else begin
      endOfConversionFlag <= next_eoc;
      startStatus         <= next_busy;
      intStatus           <= next_intStatus;
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // three-bit channel select
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pseudoIdleSelect   <= 1'b0;
      powerEnable        <= 1'b0;
      channelField       <= 3'h0;
      channelEnable      <= `RESET_BYTE;
      prescaleValue      <= `RESET_PRESCALE;
      converterIntEnable <= 1'b0;
      intMask            <= `RESET_INT;
    end else if (writeStrobe) begin
      case (address)
        `ADDR_CONTROL: begin
          pseudoIdleSelect <= writeData[`CTL_PSEUDO_IDLE_BIT];
          powerEnable      <= writeData[`CTL_POWER_ENABLE_BIT];
          // The channel must not move under a running conversion.
          if (!busy) begin
            channelField <= writeData[`CTL_CHANNEL_MSB:`CTL_CHANNEL_LSB];
          end
        end
        `ADDR_CHANNEL_ENABLE: begin
          channelEnable <= writeData;
        end
        `ADDR_CLOCK_PRESCALER: begin
          prescaleValue <= writeData[4:0];
        end
        `ADDR_SECOND_INT_ENABLE: begin
          converterIntEnable <= writeData[`SECOND_INTERRUPT_ENABLE_REG_CONVERTER_BIT];
        end
        `ADDR_INT_MASK: begin
          intMask <= writeData[1:0];
        end
        default: begin
          // Other addresses hold no writable state here.
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  // result split over two bytes
  // Reserved bits and unmapped addresses read as zero.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readData <= `RESET_BYTE;
    end else if (readStrobe) begin
      case (address)
        `ADDR_CONTROL:           readData <= {1'b0, pseudoIdleSelect, powerEnable,
                                              endOfConversionFlag, startStatus,
                                              channelField};
        `ADDR_CHANNEL_ENABLE:    readData <= channelEnable;
        `ADDR_CLOCK_PRESCALER:   readData <= {3'b000, prescaleValue};
        `ADDR_RESULT_HIGH:       readData <= result[9:2];
        `ADDR_RESULT_LOW:        readData <= {6'b00_0000, result[1:0]};
        `ADDR_SECOND_INT_ENABLE: readData <= {6'b00_0000, converterIntEnable, 1'b0};
        `ADDR_INT_STATUS:        readData <= {6'b00_0000, intStatus};
        `ADDR_INT_MASK:          readData <= {6'b00_0000, intMask};
        default:                 readData <= `RESET_BYTE;
      endcase
    end else begin
      readData <= `RESET_BYTE;
    end
  end

  // --------------------------------------------------------------------------
  // Pin and system outputs
  // --------------------------------------------------------------------------
  // All outputs are registered, so each follows its cause by one cycle.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      channelSelect     <= 3'h0;
      analogInputEnable <= `RESET_BYTE;
      converterPowerOn  <= 1'b0;
      cpuHalt           <= 1'b0;
      cpuWake           <= 1'b0;
      otherIrqRelease   <= 1'b1;
      converterIrq      <= 1'b0;
      irq               <= 1'b0;
    end else begin
      // Written values pass at once, so select, pins and power move together
      // with the engine and the multiplexer never shifts inside a sample.
      channelSelect     <= (writeControl && !busy) ?
                           writeData[`CTL_CHANNEL_MSB:`CTL_CHANNEL_LSB] : channelField;
      analogInputEnable <= (writeStrobe && address == `ADDR_CHANNEL_ENABLE) ?
                           writeData : channelEnable;
      converterPowerOn  <= writeControl ? writeData[`CTL_POWER_ENABLE_BIT] : powerEnable;
      cpuHalt           <= next_busy && (startAccepted ? writeData[`CTL_PSEUDO_IDLE_BIT] :
                                                         precisionRun);
      // flag and enable request
      // The request stays high while the flag is set; clearing it rearms.
      converterIrq      <= next_eoc && converterIntEnable;
      cpuWake           <= next_eoc && converterIntEnable && globalIntEnable;
      otherIrqRelease   <= !(next_busy && (startAccepted ?
                                           writeData[`CTL_PSEUDO_IDLE_BIT] : precisionRun));
      irq               <= |(next_intStatus & intMask);
    end
  end

  // settling wait is software's
  // The engine does not time the settling delay after power enable; a start
  // accepted too early converts with an unsettled ladder.

endmodule // adc_conversion_control

// [inc/adc_defs.vh]
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_CLOCK_PRESCALER   8'hF2
`define ADDR_CONTROL           8'hF3
`define ADDR_RESULT_LOW        8'hF4
`define ADDR_RESULT_HIGH       8'hF5
`define ADDR_CHANNEL_ENABLE    8'hF6
`define ADDR_INT_STATUS        8'hF7
`define ADDR_INT_MASK          8'hF0
`define ADDR_SECOND_INT_ENABLE 8'hF1

// ----------------------------------------------------------------------------
// Control, second interrupt enable and interrupt status register fields
// ----------------------------------------------------------------------------
`define CTL_PSEUDO_IDLE_BIT    6
`define CTL_POWER_ENABLE_BIT   5
`define CTL_EOC_BIT            4
`define CTL_START_BIT          3
`define CTL_CHANNEL_MSB        2
`define CTL_CHANNEL_LSB        0
`define SECOND_INTERRUPT_ENABLE_REG_CONVERTER_BIT     1
`define INT_DONE_BIT           0
`define INT_REFUSED_BIT        1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RESET_BYTE             8'h00
`define RESET_PRESCALE         5'h00
`define RESET_RESULT           10'h000
`define RESET_INT              2'h0

// ----------------------------------------------------------------------------
// Timing counts, in converter clock periods or peripheral clock cycles
// ----------------------------------------------------------------------------
`define SAMPLE_PERIODS         1
`define BIT_PERIODS            10
`define CONVERSION_PERIODS     11
`define PRESCALE_ZERO_DIVIDE   7'd64
`define PRESCALE_MULTIPLIER    2

`endif

// [hdl/converter_clock_divider.v]
`timescale 1ns/1ps
`include "adc_defs.vh"

// ----------------------------------------------------------------------------
// Converter clock divider
// ----------------------------------------------------------------------------
module converter_clock_divider (
  input  wire       clock,     // Peripheral clock.
  input  wire       rstn,      // Asynchronous reset, active low.
  input  wire       restart,   // Realigns the divider to a fresh period.
  input  wire [4:0] prescale,  // Prescale value from software.
  output reg        tick       // One-cycle pulse at the end of each period.
);

  reg  [6:0] count;    // Cycles elapsed in the current period.
  wire [6:0] divide;   // Cycles per converter clock period.

  assign divide = (prescale == 5'h00) ? `PRESCALE_ZERO_DIVIDE :
                  {1'b0, prescale, 1'b0};

  // The count restarts with each conversion so that every period is whole.
  // The restart edge is already the first cycle of the sample period, so the
  // count resumes at one; starting at zero would stretch that period by one.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (restart) begin
      count <= 7'h01;
      tick  <= 1'b0;
    end else if (count == divide - 7'd1) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 7'd1;
      tick  <= 1'b0;
    end
  end

endmodule // converter_clock_divider

// [testbench/comparator_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Analog multiplexer and comparator model
// ----------------------------------------
module comparator_model (
  input  wire [2:0]  channelSelect,    // Multiplexer select.
  input  wire [9:0]  trialCode,        // Ladder trial level.
  input  wire        converterPowerOn, // Analog power.
  input  wire [79:0] levels,           // Input level of each channel.
  output wire        compareAbove      // High when input is at or above trial.
);
  // select and compare
  // An unpowered comparator reads low, so a stray conversion gives zero.
  assign compareAbove = converterPowerOn & (levels[channelSelect*10 +: 10] >= trialCode);
endmodule // comparator_model

// [testbench/adc_conversion_control_assertions.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module adc_conversion_control_assertions (
  input wire       clock,             // Peripheral clock.
  input wire       rstn,              // Reset, active low.
  input wire       readStrobe,        // Read request.
  input wire [7:0] readData,          // Read data.
  input wire [2:0] channelSelect,     // Multiplexer select.
  input wire [7:0] analogInputEnable, // Converter pins.
  input wire       converterPowerOn,  // Analog power.
  input wire       sampleHold,        // Sample period.
  input wire [9:0] trialCode,         // Trial level.
  input wire       cpuHalt,           // CPU halt.
  input wire       cpuWake,           // CPU wake.
  input wire       otherIrqRelease,   // Other interrupts let through.
  input wire       converterIrq       // Converter request.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_read_idle; !$past(readStrobe) |-> readData == 8'h00; endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data without read");
  property p_wake; cpuWake |-> converterIrq; endproperty
  a_wake: assert property (p_wake) else $error("wake without converter request");
  property p_release; otherIrqRelease == !cpuHalt; endproperty
  a_release: assert property (p_release) else $error("other interrupts not held");
  property p_standby; (sampleHold || trialCode != 10'h000) |-> converterPowerOn; endproperty
  a_standby: assert property (p_standby) else $error("conversion in standby");
  property p_first_trial; $fell(sampleHold) && converterPowerOn |-> trialCode == 10'h200;
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("bad first trial");
  property p_sample_min; $rose(sampleHold) |=> sampleHold || !converterPowerOn; endproperty
  a_sample_min: assert property (p_sample_min) else $error("sample too short");
  property p_enabled; sampleHold |-> analogInputEnable[channelSelect]; endproperty
  a_enabled: assert property (p_enabled) else $error("disabled channel sampled");
  property p_sel_stable; sampleHold && $past(sampleHold) |-> $stable(channelSelect); endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("select moved");
  property p_halt_busy; cpuHalt |-> (sampleHold || trialCode != 10'h000); endproperty
  a_halt_busy: assert property (p_halt_busy) else $error("halt while idle");
endmodule // adc_conversion_control_assertions

bind adc_conversion_control adc_conversion_control_assertions checker0 (
  .clock(clock), .rstn(rstn), .readStrobe(readStrobe), .readData(readData),
  .channelSelect(channelSelect), .analogInputEnable(analogInputEnable),
  .converterPowerOn(converterPowerOn), .sampleHold(sampleHold), .trialCode(trialCode),
  .cpuHalt(cpuHalt), .cpuWake(cpuWake), .otherIrqRelease(otherIrqRelease),
  .converterIrq(converterIrq));

// [testbench/tb_adc_conversion_control.sv]
`timescale 1ns/1ps
module tb_adc_conversion_control;
  reg        clock = 0;            // Peripheral clock.
  reg        rstn = 0;             // Reset, active low.
  reg  [7:0] address = 8'h00;      // Register address.
  reg  [7:0] writeData = 8'h00;    // Write data.
  reg        writeStrobe = 0;      // Write request.
  reg        readStrobe = 0;       // Read request.
  reg        globalIntEnable = 0;  // Global enable.
  reg        otherIrqPending = 0;  // Other request.
  reg [79:0] levels = 80'h0;       // Channel levels.
  reg        rdSeen = 0;           // Read answer due.
  reg  [7:0] expQ[$];              // Expected read data.
  integer    errors = 0;           // Mismatches.
  integer    samplesChecked = 0;   // Comparisons.
  integer    i;                    // Loop index.
  wire [7:0] readData;             // Read data.
  wire       compareAbove;         // Comparator.
  wire [2:0] channelSelect;        // Select.
  wire [7:0] analogInputEnable;    // Converter pins.
  wire       converterPowerOn;     // Power.
  wire       sampleHold;           // Sample period.
  wire [9:0] trialCode;            // Trial level.
  wire       cpuHalt, cpuWake, otherIrqRelease, converterIrq, irq; // Status outputs.

  adc_conversion_control dut (.clock(clock), .rstn(rstn), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .compareAbove(compareAbove), .globalIntEnable(globalIntEnable),
    .otherIrqPending(otherIrqPending), .channelSelect(channelSelect),
    .analogInputEnable(analogInputEnable), .converterPowerOn(converterPowerOn),
    .sampleHold(sampleHold), .trialCode(trialCode), .cpuHalt(cpuHalt), .cpuWake(cpuWake),
    .otherIrqRelease(otherIrqRelease), .converterIrq(converterIrq), .irq(irq));
  comparator_model model (.channelSelect(channelSelect), .trialCode(trialCode),
    .converterPowerOn(converterPowerOn), .levels(levels), .compareAbove(compareAbove));

  // Clock, 40 ns period.
  always #20 clock = ~clock;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input string name, input [15:0] seen, input [15:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      address <= a; writeData <= d; writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
    end
  endtask
  // The expected answer is noted now and compared by the monitor.
  task rd(input [7:0] a, input [7:0] e);
    begin
      expQ.push_back(e);
      @(posedge clock);
      address <= a; readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
    end
  endtask
  task reportAndStop;
    begin
      $display("checks %0d errors %0d", samplesChecked, errors);
      if (errors == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  // Read monitor: answer is settled by the falling edge after the strobe.
  always @(posedge clock) rdSeen <= readStrobe;
  always @(negedge clock) begin
    if (rdSeen) check("readData", readData, expQ.pop_front());
  end

  // One full conversion with timing, result and interrupt checks.
  task conv(input [2:0] ch, input [4:0] clock_prescale_value, input ps);
    integer n, div;
    reg [9:0] lv;
    begin
      lv = levels[ch*10 +: 10];
      div = (clock_prescale_value == 5'h00) ? 64 : 2 * clock_prescale_value;
      wr(8'hF2, {3'b000, clock_prescale_value});
      wr(8'hF3, {1'b0, ps, 3'b101, ch});
      @(negedge clock);
      check("cpuHalt", cpuHalt, ps);
      check("otherIrqRelease", otherIrqRelease, !ps);
      check("channelSelect", channelSelect, ch);
      n = 0;
      while (sampleHold && n < 2000) begin n = n + 1; @(negedge clock); end
      check("sample length", n, div);
      n = 0;
      while (!irq && n < 2000) begin n = n + 1; @(negedge clock); end
      check("bit phase length", n, 10 * div);
      check("converterIrq", converterIrq, 1'b1);
      check("cpuWake", cpuWake, globalIntEnable);
      rd(8'hF5, lv[9:2]);
      rd(8'hF4, {6'h00, ps ? lv[1:0] : 2'b00});
      rd(8'hF3, {1'b0, ps, 3'b110, ch});
      rd(8'hF7, 8'h01);
      wr(8'hF7, 8'h03);
      wr(8'hF3, {1'b0, ps, 3'b100, ch});
      @(negedge clock);
      check("irq cleared", irq, 1'b0);
      check("converterIrq rearm", converterIrq, 1'b0);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(22647));
    for (i = 0; i < 8; i = i + 1) levels[i*10 +: 10] = 10'($urandom);
    levels[9:0] = 10'h3FF;
    levels[19:10] = 10'h000;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    // Reset values, F8 unmapped.
    for (i = 0; i < 9; i = i + 1) rd(8'hF0 + i[7:0], 8'h00);
    check("release after reset", otherIrqRelease, 1'b1);
    wr(8'hF0, 8'h01);
    wr(8'hF1, 8'h02);
    wr(8'hF6, 8'hFF);
    @(negedge clock);
    check("analogInputEnable", analogInputEnable, 8'hFF);
    wr(8'hF3, 8'h20);
    repeat (20) @(posedge clock);
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clock) globalIntEnable <= 1'($urandom);
      conv(i[2:0], (i == 0) ? 5'h00 : i[4:0], i[0]);
    end
    wr(8'hF6, 8'hF7);
    wr(8'hF3, 8'h2B);
    @(negedge clock);
    check("sampleHold refused", sampleHold, 1'b0);
    check("masked irq", irq, 1'b0);
    rd(8'hF7, 8'h02);
    rd(8'hF5, levels[79:72]);
    rd(8'hF4, {6'h00, levels[71:70]});
    wr(8'hF6, 8'hFF);
    wr(8'hF3, 8'h0A);
    @(negedge clock);
    check("sampleHold standby", sampleHold, 1'b0);
    check("converterPowerOn", converterPowerOn, 1'b0);
    rd(8'hF3, 8'h02);
    repeat (2) @(posedge clock);
    reportAndStop;
  end

  // Watchdog well past the longest expected run.
  initial begin
    #(40 * 40000);
    errors = errors + 1;
    reportAndStop;
  end
endmodule // tb_adc_conversion_control
